// file: verilog/pio_params.svh
// Purpose: constants for the programmable io port: offsets, fields, resets
// Assumes: axi4-lite, 32-bit data, one aligned word per register
// Notes: reset defaults are fixed per line; pull directions never change
`ifndef PIO_PARAMS_SVH
`define PIO_PARAMS_SVH
`define MODE_LO_OFS 12'h000
`define MODE_HI_OFS 12'h004
`define DIR_LO_OFS 12'h008
`define DIR_HI_OFS 12'h00C
`define OUT_LO_OFS 12'h010
`define OUT_HI_OFS 12'h014
`define IN_LO_OFS 12'h018
`define IN_HI_OFS 12'h01C
`define LINE_CFG_OFS 12'h020
`define CFG_LINE_LSB 0
`define CFG_MODE_LSB 8
// lines 4..9 normal (mode 0, dir 0); the rest pulled input (mode 0, dir 1)
`define MODE_LO_RST 16'h0000
`define MODE_HI_RST 16'h0000
`define DIR_LO_RST 16'hFC0F
`define DIR_HI_RST 16'hFFFF
`define PULL_UP_RST 32'hFF3FFBFD
`define OUT_RST 32'h00000000
`endif

// file: verilog/pio_pkg.sv
// Purpose: types for the programmable io port
// Assumes: nothing
// Notes: mode code is {mode bit, direction bit}
package pio_pkg;
    typedef enum logic [1:0] {
        pin_normal = 2'b00,
        pin_in_pull = 2'b01,
        pin_output = 2'b10,
        pin_in_nopull = 2'b11
    } pin_mode_e;
    typedef enum logic [1:0] {
        wr_idle = 2'b00,
        wr_resp = 2'b01
    } wr_state_e;
endpackage : pio_pkg

// file: verilog/pio_pin_cell.sv
// Purpose: one line's pad control and input synchroniser
// Assumes: pad input asynchronous to aclk
// Notes: the first sync flop is read only by the second
`timescale 1ns/10ps
module pio_pin_cell
    import pio_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic mode_bit,
    input wire logic dir_bit,
    input wire logic out_level,
    input wire logic func_out,
    input wire logic func_oe,
    input wire logic pad_i,
    output logic pad_o,
    output logic pad_oe,
    output logic pull_en,
    output logic level_sync
);
    logic meta_r;
    pin_mode_e mode;
    assign mode = pin_mode_e'({mode_bit, dir_bit});
    always_comb begin
        pad_o = 1'b0;
        pad_oe = 1'b0;
        pull_en = 1'b0;
        case (mode)
            pin_normal: begin
                pad_o = func_out;
                pad_oe = func_oe;
            end
            pin_in_pull: pull_en = 1'b1;
            pin_output: begin
                pad_o = out_level;
                pad_oe = 1'b1;
            end
            default: pull_en = 1'b0;
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= 1'b0;
            level_sync <= 1'b0;
        end else begin
            meta_r <= pad_i;
            level_sync <= meta_r;
        end
    end
endmodule : pio_pin_cell

// file: verilog/programmable_io_port_config.sv
// Purpose: 32-line programmable io port behind an axi4-lite slave
// Assumes: one write and one read outstanding at most
// Notes: unmapped addresses answer slverr, read as zero
// Notes: pad levels pass a two-flop synchroniser, so input reads lag the pins by two cycles
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "pio_params.svh"
module programmable_io_port_config
    import pio_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] func_out,
    input wire logic [31:0] func_oe,
    input wire logic [31:0] io_lines_0_to_31_i,
    output logic [31:0] io_lines_0_to_31_o,
    output logic [31:0] io_lines_0_to_31_oe,
    output logic [31:0] pull_en,
    output logic [31:0] pull_up_sel
);
    logic [15:0] pin_mode_select_lo_r;
    logic [15:0] pin_mode_select_hi_r;
    logic [15:0] pin_direction_select_lo_r;
    logic [15:0] pin_direction_select_hi_r;
    logic [31:0] out_level_r;
    logic [31:0] level_sync;
    logic [31:0] mode_all;
    logic [31:0] dir_all;
    logic [11:0] aw_addr_r;
    logic aw_have_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic w_have_r;
    wr_state_e wr_state_r;
    logic do_write;
    logic wr_hit;
    logic rd_hit;
    logic [31:0] rd_val;
    logic wr_mode_lo;
    logic wr_mode_hi;
    logic wr_dir_lo;
    logic wr_dir_hi;
    logic wr_out_lo;
    logic wr_out_hi;
    logic wr_line_cfg;
    logic line_cfg_ok;
    logic [4:0] cfg_line;
    logic [1:0] cfg_code;

    logic rd_mode_lo;
    logic rd_mode_hi;
    logic rd_dir_lo;
    logic rd_dir_hi;
    logic rd_out_lo;
    logic rd_out_hi;
    logic rd_in_lo;
    logic rd_in_hi;
    logic rd_line_cfg;

    // merge byte lanes of a write into a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
        logic [15:0] r;
        r = old;
        if (s[0]) r[7:0] = d[7:0];
        if (s[1]) r[15:8] = d[15:8];
        return r;
    endfunction : merge16

    // register match on the word index; the two byte-address bits never select
    function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ofs);
        return a[11:2] == ofs[11:2];
    endfunction : addr_is

    assign mode_all = {pin_mode_select_hi_r, pin_mode_select_lo_r};
    assign dir_all = {pin_direction_select_hi_r, pin_direction_select_lo_r};
    assign pull_up_sel = `PULL_UP_RST;

    genvar g;
    generate
        for (g = 0; g < 32; g++) begin : g_line
            pio_pin_cell u_cell (
                .aclk(aclk),
                .aresetn(aresetn),
                .mode_bit(mode_all[g]),
                .dir_bit(dir_all[g]),
                .out_level(out_level_r[g]),
                .func_out(func_out[g]),
                .func_oe(func_oe[g]),
                .pad_i(io_lines_0_to_31_i[g]),
                .pad_o(io_lines_0_to_31_o[g]),
                .pad_oe(io_lines_0_to_31_oe[g]),
                .pull_en(pull_en[g]),
                .level_sync(level_sync[g])
            );
        end
    endgenerate

    // write channel: address and data taken in either order
    assign s_axi_awready = !aw_have_r && (wr_state_r == wr_idle);
    assign s_axi_wready = !w_have_r && (wr_state_r == wr_idle);
    assign do_write = aw_have_r && w_have_r && (wr_state_r == wr_idle);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            aw_addr_r <= 12'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end else if (do_write) begin
            aw_have_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_r <= 1'b0;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end else if (do_write) begin
            w_have_r <= 1'b0;
        end
    end

    // decoded once, so the write response and the register updates use the same address match
    assign wr_mode_lo = addr_is(aw_addr_r, `MODE_LO_OFS);
    assign wr_mode_hi = addr_is(aw_addr_r, `MODE_HI_OFS);
    assign wr_dir_lo = addr_is(aw_addr_r, `DIR_LO_OFS);
    assign wr_dir_hi = addr_is(aw_addr_r, `DIR_HI_OFS);
    assign wr_out_lo = addr_is(aw_addr_r, `OUT_LO_OFS);
    assign wr_out_hi = addr_is(aw_addr_r, `OUT_HI_OFS);
    assign wr_line_cfg = addr_is(aw_addr_r, `LINE_CFG_OFS);
    // a line-config word missing a low lane is dropped: half a command could hit a wrong line
    assign line_cfg_ok = wr_line_cfg && w_strb_r[0] && w_strb_r[1];
    assign cfg_line = w_data_r[`CFG_LINE_LSB +: 5];
    assign cfg_code = w_data_r[`CFG_MODE_LSB +: 2];

    always_comb begin
        wr_hit = 1'b0;
        if (wr_mode_lo || wr_mode_hi) begin
            wr_hit = 1'b1;
        end else if (wr_dir_lo || wr_dir_hi) begin
            wr_hit = 1'b1;
        end else if (wr_out_lo || wr_out_hi) begin
            wr_hit = 1'b1;
        end else if (wr_line_cfg) begin
            wr_hit = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_r <= wr_idle;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            case (wr_state_r)
                wr_idle: begin
                    if (do_write) begin
                        wr_state_r <= wr_resp;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= wr_hit ? 2'b00 : 2'b10;
                    end
                end
                wr_resp: begin
                    if (s_axi_bready) begin
                        wr_state_r <= wr_idle;
                        s_axi_bvalid <= 1'b0;
                    end
                end
                default: wr_state_r <= wr_idle;
            endcase
        end
    end

    // mode and direction registers; the line-config port rewrites one line only
    // bit 4 of the line number picks the lower or the upper register pair
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_mode_select_lo_r <= `MODE_LO_RST;
        end else if (do_write && wr_mode_lo) begin
            pin_mode_select_lo_r <= merge16(pin_mode_select_lo_r, w_data_r, w_strb_r);
        end else if (do_write && line_cfg_ok && !cfg_line[4]) begin
            pin_mode_select_lo_r[cfg_line[3:0]] <= cfg_code[1];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_mode_select_hi_r <= `MODE_HI_RST;
        end else if (do_write && wr_mode_hi) begin
            pin_mode_select_hi_r <= merge16(pin_mode_select_hi_r, w_data_r, w_strb_r);
        end else if (do_write && line_cfg_ok && cfg_line[4]) begin
            pin_mode_select_hi_r[cfg_line[3:0]] <= cfg_code[1];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_direction_select_lo_r <= `DIR_LO_RST;
        end else if (do_write && wr_dir_lo) begin
            pin_direction_select_lo_r <= merge16(pin_direction_select_lo_r, w_data_r, w_strb_r);
        end else if (do_write && line_cfg_ok && !cfg_line[4]) begin
            pin_direction_select_lo_r[cfg_line[3:0]] <= cfg_code[0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_direction_select_hi_r <= `DIR_HI_RST;
        end else if (do_write && wr_dir_hi) begin
            pin_direction_select_hi_r <= merge16(pin_direction_select_hi_r, w_data_r, w_strb_r);
        end else if (do_write && line_cfg_ok && cfg_line[4]) begin
            pin_direction_select_hi_r[cfg_line[3:0]] <= cfg_code[0];
        end
    end

    // output levels are stored for every line but reach the pad only in output mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_level_r <= `OUT_RST;
        end else if (do_write) begin
            if (wr_out_lo) begin
                out_level_r[15:0] <= merge16(out_level_r[15:0], w_data_r, w_strb_r);
            end else if (wr_out_hi) begin
                out_level_r[31:16] <= merge16(out_level_r[31:16], w_data_r, w_strb_r);
            end
        end
    end

    // read channel
    assign s_axi_arready = !s_axi_rvalid;

    assign rd_mode_lo = addr_is(s_axi_araddr, `MODE_LO_OFS);
    assign rd_mode_hi = addr_is(s_axi_araddr, `MODE_HI_OFS);
    assign rd_dir_lo = addr_is(s_axi_araddr, `DIR_LO_OFS);
    assign rd_dir_hi = addr_is(s_axi_araddr, `DIR_HI_OFS);
    assign rd_out_lo = addr_is(s_axi_araddr, `OUT_LO_OFS);
    assign rd_out_hi = addr_is(s_axi_araddr, `OUT_HI_OFS);
    assign rd_in_lo = addr_is(s_axi_araddr, `IN_LO_OFS);
    assign rd_in_hi = addr_is(s_axi_araddr, `IN_HI_OFS);
    assign rd_line_cfg = addr_is(s_axi_araddr, `LINE_CFG_OFS);

    // the line-config word is write-only and reads back as zero
    always_comb begin
        rd_hit = 1'b1;
        rd_val = 32'h00000000;
        if (rd_mode_lo) begin
            rd_val = {16'h0000, pin_mode_select_lo_r};
        end else if (rd_mode_hi) begin
            rd_val = {16'h0000, pin_mode_select_hi_r};
        end else if (rd_dir_lo) begin
            rd_val = {16'h0000, pin_direction_select_lo_r};
        end else if (rd_dir_hi) begin
            rd_val = {16'h0000, pin_direction_select_hi_r};
        end else if (rd_out_lo) begin
            rd_val = {16'h0000, out_level_r[15:0]};
        end else if (rd_out_hi) begin
            rd_val = {16'h0000, out_level_r[31:16]};
        end else if (rd_in_lo) begin
            rd_val = {16'h0000, level_sync[15:0]};
        end else if (rd_in_hi) begin
            rd_val = {16'h0000, level_sync[31:16]};
        end else if (rd_line_cfg) begin
            rd_val = 32'h00000000;
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule : programmable_io_port_config

// file: tb/programmable_io_port_config_assertions.sv
// Purpose: port-level checks for the programmable io port
// Assumes: synchronous active-low reset on aclk
// Notes: sees only the top module's ports
`timescale 1ns/10ps
`include "pio_params.svh"
module programmable_io_port_config_assertions (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] io_lines_0_to_31_oe,
    input wire logic [31:0] pull_en,
    input wire logic [31:0] pull_up_sel
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_no_pull_drive: assert property ((pull_en & io_lines_0_to_31_oe) == 32'h0)
        else $error("pulled line is also driven");
    chk_pull_dir_fixed: assert property (pull_up_sel == `PULL_UP_RST)
        else $error("pull direction changed");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
                                    s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
                                       s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
                                    s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_arready_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    chk_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 12'h040
                                        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
endmodule : programmable_io_port_config_assertions
bind programmable_io_port_config
    programmable_io_port_config_assertions programmable_io_port_config_assertions_i (.*);

// file: tb/test_programmable_io_port_config.sv
// Purpose: self-checking bench for the programmable io port
// Assumes: axi4-lite master driven by non-blocking assignment on rising edges
// Notes: ready and pins are sampled at the falling edge, where they have settled
`timescale 1ns/10ps
`include "pio_params.svh"
module test_programmable_io_port_config;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, io_lines_0_to_31_i = 32'h0;
    logic [31:0] func_out = 32'h0F0F_3C3C, func_oe = 32'hA5A5_5A5A;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, io_lines_0_to_31_o, io_lines_0_to_31_oe, pull_en, pull_up_sel;
    int errors = 0, checked = 0;
    logic [1:0] md [32];
    programmable_io_port_config programmable_io_port_config_i (.*);
    always #50 aclk = ~aclk;
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, hb;
        int n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            hb = s_axi_bvalid && s_axi_bready;
            r = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (hb) s_axi_bready <= 1'b0;
            n++;
        end while (!hb && n < 50);
        if (!hb) begin
            errors++;
            $display("BAD t=%0t write response timeout", $time);
        end
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, hr;
        int n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            hr = s_axi_rvalid && s_axi_rready;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (hr) s_axi_rready <= 1'b0;
            n++;
        end while (!hr && n < 50);
        if (!hr) begin
            errors++;
            $display("BAD t=%0t read response timeout", $time);
        end
    endtask : rd
    // expected drive and pull follow the tracked per-line mode codes
    task automatic check_pins();
        logic [31:0] oe, pe;
        for (int i = 0; i < 32; i++) begin
            oe[i] = (md[i] == 2'h2) | ((md[i] == 2'h0) & func_oe[i]);
            pe[i] = (md[i] == 2'h1);
        end
        @(negedge aclk);
        check(io_lines_0_to_31_oe, oe, "drive enables");
        check(pull_en, pe, "pull enables");
    endtask : check_pins
    task automatic test_reset();
        logic [11:0] a [4] = '{`MODE_LO_OFS, `MODE_HI_OFS, `DIR_LO_OFS, `DIR_HI_OFS};
        logic [15:0] e [4] = '{`MODE_LO_RST, `MODE_HI_RST, `DIR_LO_RST, `DIR_HI_RST};
        logic [31:0] d;
        logic [1:0] r;
        for (int k = 0; k < 4; k++) begin
            rd(a[k], d, r);
            check(d & 32'h0000FFFF, {16'h0, e[k]}, "reset value");
        end
        check_pins();
        check(io_lines_0_to_31_o & 32'h000003F0, func_out & 32'h000003F0, "normal drive");
        check(pull_up_sel, `PULL_UP_RST, "pull directions");
        $display("test_reset done");
    endtask : test_reset
    task automatic test_modes();
        int ln [2] = '{3, 20};
        logic [31:0] d;
        logic [1:0] r;
        for (int k = 0; k < 2; k++) begin
            for (int m = 0; m < 4; m++) begin
                wr(`LINE_CFG_OFS, 32'((m << `CFG_MODE_LSB) | (ln[k] << `CFG_LINE_LSB)), r);
                md[ln[k]] = m[1:0];
                check_pins();
                rd(ln[k] < 16 ? `MODE_LO_OFS : `MODE_HI_OFS, d, r);
                check(d[ln[k] % 16], m[1], "mode bit");
                rd(ln[k] < 16 ? `DIR_LO_OFS : `DIR_HI_OFS, d, r);
                check(d[ln[k] % 16], m[0], "direction bit");
            end
        end
        $display("test_modes done");
    endtask : test_modes
    task automatic test_input();
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        io_lines_0_to_31_i <= 32'hC3A5_96E1;
        repeat (3) @(posedge aclk);
        rd(`IN_LO_OFS, d, r);
        check(d & 32'h0000FFFF, 32'h96E1, "group 0");
        rd(`IN_HI_OFS, d, r);
        check(d & 32'h0000FFFF, 32'hC3A5, "group 1");
        wr(`IN_LO_OFS, 32'h0, r);
        rd(`IN_LO_OFS, d, r);
        check(d & 32'h0000FFFF, 32'h96E1, "group 0 after write");
        $display("test_input done");
    endtask : test_input
    task automatic test_output();
        logic [1:0] r;
        wr(`MODE_LO_OFS, 32'hFFFF, r);
        wr(`DIR_LO_OFS, 32'h0, r);
        wr(`OUT_LO_OFS, 32'h5A5A, r);
        wr(`OUT_HI_OFS, 32'hFFFF, r);
        for (int i = 0; i < 16; i++) md[i] = 2'h2;
        check_pins();
        check(io_lines_0_to_31_o & 32'h0000FFFF, 32'h5A5A, "drive level");
        wr(`OUT_LO_OFS, 32'hA5A5, r);
        @(negedge aclk);
        check(io_lines_0_to_31_o & 32'h0000FFFF, 32'hA5A5, "new level");
        $display("test_output done");
    endtask : test_output
    task automatic test_errors();
        logic [31:0] d;
        logic [1:0] r;
        rd(12'h040, d, r);
        check(r, 2'h2, "unmapped read response");
        check(d, 32'h0, "unmapped read data");
        wr(12'h040, 32'h0, r);
        check(r, 2'h2, "unmapped write");
        rd(`MODE_LO_OFS, d, r);
        check(d & 32'h0000FFFF, 32'hFFFF, "mode kept");
        $display("test_errors done");
    endtask : test_errors
    task automatic end_of_test();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        for (int i = 0; i < 32; i++) md[i] = (i >= 4 && i <= 9) ? 2'h0 : 2'h1;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        test_reset();
        test_modes();
        test_input();
        test_output();
        test_errors();
        end_of_test();
    end
    // the tests need well under a thousand cycles
    initial begin
        #2000000;
        errors++;
        $display("BAD t=%0t watchdog expired", $time);
        end_of_test();
    end
endmodule : test_programmable_io_port_config
